// File: rtl/i2cbm_engine.sv
// buffered i2c master and slave engine with shared byte memory
`timescale 1ns/100ps
// How it works
// - master nak after read byte sets read-done
// - read-active on read address, drops at done
// - reading past buffer end sets read-overrun
// - stop ending our write sets write-done
// - write-active on write address, drops at done
// - byte past write buffer: nak, write-overrun
// - read status clear touches only read flags
// - write status clear touches only write flags
// - own 7-bit address matched without r/w bit
// - read setup loads base, length, zero count
// - write setup loads base, length, zero count
// - read count saturates at read length
// - write count saturates at write length
// - read buffer clear restarts at first entry
// - write buffer clear restarts at first entry
// - master flags independent, read with errors
// - master done flags set even after short, address or arbitration errors
// - paused transfer holds bus awaiting restart
// - early slave nak on write: short error
// - address nak sets address error
// - arbitration error; any-error ors all errors
// - master clear returns then clears all flags
// - master write sends whole buffer bytewise
// - repeated start and no-stop options
// - unconfigured: read gives ff, write naks
module i2cbm_engine (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // i2c pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // slave control and status
  input wire logic [6:0] own_addr,
  input wire logic sl_rd_setup,
  input wire logic sl_wr_setup,
  input wire i2cbm_pkg::i2cbm_buf_s sl_buf_cfg,
  input wire logic sl_rd_clear,
  input wire logic sl_wr_clear,
  input wire logic sl_rd_stat_clear,
  input wire logic sl_wr_stat_clear,
  output i2cbm_pkg::i2cbm_sstat_s sl_status,
  output logic [7:0] sl_rd_count,
  output logic [7:0] sl_wr_count,
  // master control and status
  input wire logic m_launch,
  input wire i2cbm_pkg::i2cbm_mcmd_s m_cmd_in,
  input wire logic m_stat_clear,
  output i2cbm_pkg::i2cbm_mstat_s m_status,
  output logic [7:0] m_count,
  // buffer memory port
  input wire logic mem_we,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  // interrupt
  output logic irq
);
  import i2cbm_pkg::*;

  i2cbm_syn_s syn_reg, syn_next;
  i2cbm_slv_s slv_reg, slv_next;
  i2cbm_mst_s mst_reg, mst_next;
  logic [7:0] mem [I2CBM_MEM_DEPTH];
  logic [7:0] mem_rdata_reg;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  logic [7:0] rd_addr, wr_addr, m_addr, rd_byte, m_byte;
  logic sl_we, m_we, m_run, m_tick, m_adv, m_txp;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // pin synchronisers and bus events
  always_comb begin
    syn_next.scl = {syn_reg.scl[1:0], scl_i};
    syn_next.sda = {syn_reg.sda[1:0], sda_i};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syn_reg <= I2CBM_SYN_RST;
    end else if (ce) begin
      syn_reg <= syn_next;
    end
  end

  // stage 0 feeds stage 1 only; events look at stages 1 and 2
  assign scl_s = syn_reg.scl[1];
  assign sda_s = syn_reg.sda[1];
  assign scl_rise = scl_s & ~syn_reg.scl[2];
  assign scl_fall = ~scl_s & syn_reg.scl[2];
  assign start_det = scl_s & syn_reg.scl[2] & ~sda_s & syn_reg.sda[2];
  assign stop_det = scl_s & syn_reg.scl[2] & sda_s & ~syn_reg.sda[2];

  // ==========================================================
  // slave
  assign rd_addr = 8'(slv_reg.rd_buf.base + slv_reg.rd_pos);
  assign wr_addr = 8'(slv_reg.wr_buf.base + slv_reg.wr_pos);
  assign rd_byte = (slv_reg.rd_cfg && slv_reg.rd_pos != slv_reg.rd_buf.len)
    ? mem[rd_addr] : I2CBM_IDLE_BYTE;

  always_comb begin
    logic ld;
    ld = 1'b0;
    slv_next = slv_reg;
    sl_we = 1'b0;
    // clears first so that a same-cycle bus event wins
    if (sl_rd_stat_clear) begin
      slv_next.ss.rd_done = 1'b0;
      slv_next.ss.rd_overrun = 1'b0;
    end
    if (sl_wr_stat_clear) begin
      slv_next.ss.wr_done = 1'b0;
      slv_next.ss.wr_overrun = 1'b0;
    end
    if (stop_det) begin
      if (slv_reg.ss.wr_active) begin
        slv_next.ss.wr_done = 1'b1;
        slv_next.ss.wr_active = 1'b0;
      end
      slv_next.st = SL_IDLE;
      slv_next.low = 1'b0;
    end else if (start_det) begin
      slv_next.st = SL_ADDR;
      slv_next.cnt = 4'h0;
      slv_next.low = 1'b0;
    end else begin
      case (slv_reg.st)
        SL_ADDR, SL_RX: begin
          if (scl_rise) begin
            slv_next.sh = {slv_reg.sh[6:0], sda_s};
            slv_next.cnt = 4'(slv_reg.cnt + 4'h1);
          end else if (scl_fall && slv_reg.cnt == I2CBM_BYTE_BITS) begin
            slv_next.st = SL_ACK;
            if (slv_reg.st == SL_ADDR) begin
              slv_next.ack = slv_reg.sh[7:1] == own_addr;
              slv_next.dir = slv_reg.sh[0];
              if (slv_next.ack && slv_reg.sh[0])
                slv_next.ss.rd_active = 1'b1;
              if (slv_next.ack && !slv_reg.sh[0])
                slv_next.ss.wr_active = 1'b1;
            end else begin
              slv_next.ack = slv_reg.wr_cfg &&
                slv_reg.wr_pos != slv_reg.wr_buf.len;
              if (slv_reg.wr_cfg && !slv_next.ack)
                slv_next.ss.wr_overrun = 1'b1;
              sl_we = slv_next.ack;
              if (slv_next.ack)
                slv_next.wr_pos = 8'(slv_reg.wr_pos + 8'h01);
            end
            slv_next.low = slv_next.ack;
          end
        end
        SL_ACK: begin
          if (scl_fall) begin
            slv_next.low = 1'b0;
            slv_next.cnt = 4'h0;
            if (!slv_reg.ack) slv_next.st = SL_IDLE;
            else if (slv_reg.dir) ld = 1'b1;
            else slv_next.st = SL_RX;
          end
        end
        SL_TX: begin
          if (scl_rise) begin
            slv_next.cnt = 4'(slv_reg.cnt + 4'h1);
          end else if (scl_fall) begin
            if (slv_reg.cnt == I2CBM_BYTE_BITS) begin
              slv_next.low = 1'b0;
              slv_next.st = SL_MACK;
            end else begin
              slv_next.sh = {slv_reg.sh[6:0], 1'b0};
              slv_next.low = ~slv_reg.sh[6];
            end
          end
        end
        SL_MACK: begin
          if (scl_rise && sda_s) begin
            slv_next.ss.rd_done = 1'b1;
            slv_next.ss.rd_active = 1'b0;
            slv_next.st = SL_IDLE;
          end else if (scl_fall) begin
            ld = 1'b1;
          end
        end
        default: slv_next.st = SL_IDLE;
      endcase
    end
    if (ld) begin
      slv_next.st = SL_TX;
      slv_next.cnt = 4'h0;
      slv_next.sh = rd_byte;
      slv_next.low = ~rd_byte[7];
      if (slv_reg.rd_cfg && slv_reg.rd_pos == slv_reg.rd_buf.len)
        slv_next.ss.rd_overrun = 1'b1;
      else if (slv_reg.rd_cfg)
        slv_next.rd_pos = 8'(slv_reg.rd_pos + 8'h01);
    end
    // setup may land mid-transfer; mixing old and new data is allowed
    if (sl_rd_setup) begin
      slv_next.rd_buf = sl_buf_cfg;
      slv_next.rd_cfg = 1'b1;
    end
    if (sl_wr_setup) begin
      slv_next.wr_buf = sl_buf_cfg;
      slv_next.wr_cfg = 1'b1;
    end
    if (sl_rd_setup || sl_rd_clear) slv_next.rd_pos = 8'h00;
    if (sl_wr_setup || sl_wr_clear) slv_next.wr_pos = 8'h00;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slv_reg <= I2CBM_SLV_RST;
    end else if (ce) begin
      slv_reg <= slv_next;
    end
  end

  chk_rd_done_drop: assert property (
    $rose(sl_status.rd_done) |-> !sl_status.rd_active &&
    $past(slv_reg.st) == SL_MACK) else $error("read done bad");
  chk_wr_done_stop: assert property (
    $rose(sl_status.wr_done) |-> $past(stop_det) &&
    !sl_status.wr_active) else $error("write done bad");
  chk_wr_ovf_nak: assert property (
    $rose(sl_status.wr_overrun) |-> slv_reg.st == SL_ACK &&
    !slv_reg.low) else $error("overrun byte acked");
  chk_rd_clr_keep: assert property (
    ce && sl_rd_stat_clear && !sl_wr_stat_clear && sl_status.wr_done
    |=> sl_status.wr_done) else $error("read clear hit write");
  chk_wr_clr_keep: assert property (
    ce && sl_wr_stat_clear && !sl_rd_stat_clear && sl_status.rd_done
    |=> sl_status.rd_done) else $error("write clear hit read");
  chk_rd_count_sat: assert property (
    slv_reg.rd_cfg |-> slv_reg.rd_pos <= slv_reg.rd_buf.len)
    else $error("read count past length");
  chk_wr_setup_zero: assert property (
    ce && sl_wr_setup |=> slv_reg.wr_pos == 8'h00 &&
    slv_reg.wr_cfg) else $error("write setup failed");

  // ==========================================================
  // master
  assign m_addr = 8'(mst_reg.cmd.bufr.base + mst_reg.pos);
  assign m_byte = mem[m_addr];
  assign m_run = mst_reg.st == M_START || mst_reg.st == M_BIT ||
    mst_reg.st == M_STOP;
  assign m_tick = mst_reg.div == I2CBM_QTR_LAST;
  // a slave stretching scl holds the high quarter
  assign m_adv = m_tick && !(mst_reg.q == 2'h2 && !scl_s);
  assign m_txp = mst_reg.isa || !mst_reg.cmd.rd;

  always_comb begin
    logic fin, bad, done;
    fin = 1'b0;
    bad = 1'b0;
    done = 1'b0;
    mst_next = mst_reg;
    m_we = 1'b0;
    mst_next.div = (m_run && !m_tick) ? 8'(mst_reg.div + 8'h01) : 8'h00;
    if (m_stat_clear) mst_next.mf = I2CBM_MFLAG_RST;
    if (m_adv) mst_next.q = 2'(mst_reg.q + 2'h1);
    case (mst_reg.st)
      M_IDLE, M_HALT: begin
        if (m_launch) begin
          if (sl_status.rd_active || sl_status.wr_active) begin
            mst_next.mf.abort = 1'b1;
          end else if (mst_reg.st == M_IDLE ||
                       m_cmd_in.mode[I2CBM_MODE_RS]) begin
            mst_next.cmd = m_cmd_in;
            mst_next.st = M_START;
            mst_next.q = 2'h0;
            mst_next.pos = 8'h00;
          end
        end
      end
      M_START: begin
        if (m_adv) begin
          case (mst_reg.q)
            2'h0: mst_next.sdl = 1'b0;
            2'h1: mst_next.scl = 1'b0;
            2'h2: mst_next.sdl = 1'b1;
            default: begin
              mst_next.scl = 1'b1;
              mst_next.st = M_BIT;
              mst_next.cnt = 4'h0;
              mst_next.isa = 1'b1;
              mst_next.sh = {mst_reg.cmd.addr, mst_reg.cmd.rd};
            end
          endcase
        end
      end
      M_BIT: begin
        if (m_adv) begin
          case (mst_reg.q)
            2'h0: begin
              if (mst_reg.cnt == I2CBM_BYTE_BITS) begin
                mst_next.sdl = mst_reg.cmd.rd && !mst_reg.isa &&
                  8'(mst_reg.pos + 8'h01) != mst_reg.cmd.bufr.len;
              end else if (m_txp && mst_reg.cnt == 4'h0 && !mst_reg.isa) begin
                mst_next.sh = m_byte;
                mst_next.sdl = ~m_byte[7];
              end else begin
                mst_next.sdl = m_txp && !mst_reg.sh[7];
              end
            end
            2'h1: mst_next.scl = 1'b0;
            2'h2: begin
              if (mst_reg.cnt == I2CBM_BYTE_BITS) begin
                mst_next.ack = ~sda_s;
              end else if (m_txp && !mst_reg.sdl && !sda_s) begin
                mst_next.mf.arb_err = 1'b1;
                mst_next.sdl = 1'b0;
                mst_next.scl = 1'b0;
                mst_next.st = M_IDLE;
                done = 1'b1;
              end else begin
                mst_next.sh = {mst_reg.sh[6:0], sda_s};
              end
            end
            default: begin
              mst_next.scl = 1'b1;
              mst_next.cnt = 4'(mst_reg.cnt + 4'h1);
              if (mst_reg.cnt == I2CBM_BYTE_BITS) begin
                mst_next.cnt = 4'h0;
                mst_next.isa = 1'b0;
                if (mst_reg.isa) begin
                  if (!mst_reg.ack) begin
                    mst_next.mf.addr_err = 1'b1;
                    bad = 1'b1;
                  end
                  fin = !mst_reg.ack || mst_reg.cmd.bufr.len == 8'h00;
                end else begin
                  m_we = mst_reg.cmd.rd;
                  mst_next.pos = 8'(mst_reg.pos + 8'h01);
                  if (8'(mst_reg.pos + 8'h01) == mst_reg.cmd.bufr.len) begin
                    fin = 1'b1;
                  end else if (!mst_reg.cmd.rd && !mst_reg.ack) begin
                    mst_next.mf.short_err = 1'b1;
                    fin = 1'b1;
                    bad = 1'b1;
                  end
                end
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (m_adv) begin
          case (mst_reg.q)
            2'h0: mst_next.sdl = 1'b1;
            2'h1: mst_next.scl = 1'b0;
            2'h2: mst_next.sdl = 1'b0;
            default: mst_next.st = M_IDLE;
          endcase
        end
      end
      default: mst_next.st = M_IDLE;
    endcase
    if (fin) begin
      done = 1'b1;
      // halt keeps scl low so no other master can take the bus
      mst_next.st = (mst_reg.cmd.mode[I2CBM_MODE_NS] && !bad)
        ? M_HALT : M_STOP;
    end
    if (done && mst_reg.cmd.rd) mst_next.mf.rd_done = 1'b1;
    if (done && !mst_reg.cmd.rd) mst_next.mf.wr_done = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mst_reg <= I2CBM_MST_RST;
    end else if (ce) begin
      mst_reg <= mst_next;
    end
  end

  sequence s_launch;
    ce && m_launch && mst_reg.st == M_IDLE && !sl_status.rd_active &&
    !sl_status.wr_active;
  endsequence
  chk_launch_go: assert property (s_launch |=> mst_reg.st == M_START)
    else $error("launch not taken");
  chk_pause_hold: assert property (mst_reg.st == M_HALT |-> scl_oe &&
    m_status.paused && !m_status.active)
    else $error("pause releases scl");
  chk_addr_done: assert property ($rose(m_status.addr_err) |->
    m_status.rd_done || m_status.wr_done)
    else $error("address error without done");
  chk_mst_clear: assert property (ce && m_stat_clear && !m_launch &&
    mst_reg.st == M_IDLE |=> mst_reg.mf == I2CBM_MFLAG_RST)
    else $error("master clear failed");

  // ==========================================================
  // shared memory; bus writes win over the cpu port
  always_ff @(posedge clk) begin
    if (ce) begin
      if (sl_we) mem[wr_addr] <= slv_reg.sh;
      else if (m_we) mem[m_addr] <= mst_reg.sh;
      else if (mem_we) mem[mem_addr] <= mem_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_rdata_reg <= 8'h00;
    end else if (ce) begin
      mem_rdata_reg <= mem[mem_addr];
    end
  end

  // ==========================================================
  // outputs
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = mst_reg.scl;
  assign sda_oe = slv_reg.low | mst_reg.sdl;
  assign sl_status = slv_reg.ss;
  assign sl_rd_count = slv_reg.rd_pos;
  assign sl_wr_count = slv_reg.wr_pos;
  assign m_count = mst_reg.pos;
  assign mem_rdata = mem_rdata_reg;
  always_comb begin
    m_status.rd_done = mst_reg.mf.rd_done;
    m_status.wr_done = mst_reg.mf.wr_done;
    m_status.active = m_run;
    m_status.paused = mst_reg.st == M_HALT;
    m_status.short_err = mst_reg.mf.short_err;
    m_status.addr_err = mst_reg.mf.addr_err;
    m_status.arb_err = mst_reg.mf.arb_err;
    m_status.any_err = mst_reg.mf.short_err | mst_reg.mf.addr_err |
      mst_reg.mf.arb_err | mst_reg.mf.abort;
  end
  assign irq = sl_status.rd_done | sl_status.rd_overrun |
    sl_status.wr_done | sl_status.wr_overrun | m_status.rd_done |
    m_status.wr_done | m_status.any_err;

endmodule : i2cbm_engine

// File: rtl/i2cbm_pkg.sv
// package: constants and types of the buffered i2c engine
package i2cbm_pkg;

  // ==========================================================
  // timing
  localparam int unsigned I2CBM_CLK_HZ = 50_000_000;
  localparam int unsigned I2CBM_BUS_HZ = 100_000;
  // quarter bit period, rounded down, at least one cycle
  localparam int unsigned I2CBM_QTR_RAW = I2CBM_CLK_HZ / (4 * I2CBM_BUS_HZ);
  localparam int unsigned I2CBM_QTR_CYC =
    (I2CBM_QTR_RAW < 1) ? 1 : I2CBM_QTR_RAW;
  localparam logic [7:0] I2CBM_QTR_LAST = 8'(I2CBM_QTR_CYC - 1);

  // ==========================================================
  // fields and values
  localparam logic [3:0] I2CBM_BYTE_BITS = 4'h8;
  localparam logic [7:0] I2CBM_IDLE_BYTE = 8'hFF;
  localparam int unsigned I2CBM_MEM_DEPTH = 256;
  localparam int unsigned I2CBM_MODE_RS = 0;
  localparam int unsigned I2CBM_MODE_NS = 1;
  localparam logic [1:0] I2CBM_FULL_TRANSFER_OPTION = 2'h0;
  localparam logic [2:0] I2CBM_SYNC_RST = 3'h7;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SL_IDLE = 3'b000, SL_ADDR = 3'b001, SL_RX = 3'b010,
    SL_ACK = 3'b011, SL_TX = 3'b100, SL_MACK = 3'b101
  } i2cbm_sl_e;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_START = 3'b001, M_BIT = 3'b010,
    M_STOP = 3'b011, M_HALT = 3'b100
  } i2cbm_m_e;

  typedef struct packed {
    logic [7:0] base;
    logic [7:0] len;
  } i2cbm_buf_s;

  typedef struct packed {
    logic rd_done;
    logic rd_active;
    logic rd_overrun;
    logic wr_done;
    logic wr_active;
    logic wr_overrun;
  } i2cbm_sstat_s;

  typedef struct packed {
    logic rd_done;
    logic wr_done;
    logic active;
    logic paused;
    logic short_err;
    logic addr_err;
    logic arb_err;
    logic any_err;
  } i2cbm_mstat_s;

  typedef struct packed {
    logic rd_done;
    logic wr_done;
    logic short_err;
    logic addr_err;
    logic arb_err;
    logic abort;
  } i2cbm_mflag_s;

  typedef struct packed {
    logic [6:0] addr;
    logic rd;
    i2cbm_buf_s bufr;
    logic [1:0] mode;
  } i2cbm_mcmd_s;

  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
  } i2cbm_syn_s;

  typedef struct packed {
    i2cbm_sl_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic low;
    logic ack;
    logic dir;
    logic [7:0] rd_pos;
    logic [7:0] wr_pos;
    logic rd_cfg;
    logic wr_cfg;
    i2cbm_buf_s rd_buf;
    i2cbm_buf_s wr_buf;
    i2cbm_sstat_s ss;
  } i2cbm_slv_s;

  typedef struct packed {
    i2cbm_m_e st;
    logic [1:0] q;
    logic [7:0] div;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic sdl;
    logic scl;
    logic isa;
    logic ack;
    logic [7:0] pos;
    i2cbm_mcmd_s cmd;
    i2cbm_mflag_s mf;
  } i2cbm_mst_s;

  localparam i2cbm_syn_s I2CBM_SYN_RST = {I2CBM_SYNC_RST, I2CBM_SYNC_RST};
  localparam i2cbm_slv_s I2CBM_SLV_RST = '0;
  localparam i2cbm_mst_s I2CBM_MST_RST = '0;
  localparam i2cbm_mflag_s I2CBM_MFLAG_RST = '0;

endpackage : i2cbm_pkg

// File: verif/i2cbm_bus_partner.sv
// bus partner: outside i2c master tasks and an outside slave
`timescale 1ns/100ps
module i2cbm_bus_partner #(
  parameter logic [6:0] SLV_ADDR = 7'h2B,
  parameter int HALF_NS = 80
) (
  // resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // pull-low requests
  output logic scl_low,
  output logic sda_low
);
  logic ms_scl = 1'b0;
  logic ms_sda = 1'b0;
  logic sl_sda = 1'b0;
  logic b = 1'b0;
  logic stp = 1'b0;
  logic rs = 1'b0;
  logic hit = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] got[$];
  int nak_at = 255;
  int idx = 0;
  assign scl_low = ms_scl;
  assign sda_low = ms_sda | sl_sda;

  // ==========================================================
  // outside master; scl stands high between frames
  task automatic m_start();
    ms_sda = 1'b1;
    #HALF_NS;
    ms_scl = 1'b1;
    #HALF_NS;
  endtask : m_start

  // a 1 releases sda, so tx[0]=1 leaves the ack bit to the far end
  task automatic m_byte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      ms_sda = ~tx[i];
      #HALF_NS;
      ms_scl = 1'b0;
      #HALF_NS;
      rx[i] = sda;
      ms_scl = 1'b1;
      // sda moves well after the fall: no false start or stop
      #20;
    end
  endtask : m_byte

  task automatic m_stop();
    ms_sda = 1'b1;
    #HALF_NS;
    ms_scl = 1'b0;
    #HALF_NS;
    ms_sda = 1'b0;
    #HALF_NS;
  endtask : m_stop

  // ==========================================================
  // outside slave; nak_at picks the byte to refuse, 0 = address
  task automatic s_bit();
    @(posedge scl);
    b = sda;
    fork
      @(negedge scl);
      @(posedge sda iff scl) stp = 1'b1;
      @(negedge sda iff scl) rs = 1'b1;
    join_any
    disable fork;
  endtask : s_bit

  always begin : slave_role
    if (!rs) @(negedge sda iff scl === 1'b1);
    rs = 1'b0;
    stp = 1'b0;
    idx = 0;
    hit = 1'b0;
    while (!stp && !rs) begin
      for (int i = 0; i < 8; i++) begin
        if (!stp && !rs) s_bit();
        sh = {sh[6:0], b};
      end
      if (!stp && !rs) begin
        if (idx == 0) hit = (sh[7:1] == SLV_ADDR) && !sh[0];
        else if (hit) got.push_back(sh);
        sl_sda = hit && (idx != nak_at);
        s_bit();
        sl_sda = 1'b0;
        idx++;
      end
    end
  end
endmodule : i2cbm_bus_partner

// File: verif/test_i2c_buffered_master_slave.sv
// testbench: scenario tasks for the buffered i2c engine
`timescale 1ns/100ps
`define CMP(nm, ex, ac) begin samples_checked++; \
  if ((ac) !== (ex)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, ac); end end
module test_i2c_buffered_master_slave;
  import i2cbm_pkg::*;
  localparam logic [6:0] FAR = 7'h2B;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] own = 7'h7F;
  logic rd_su = 1'b0, wr_su = 1'b0, rd_cl = 1'b0, wr_cl = 1'b0;
  logic rd_sc = 1'b0, wr_sc = 1'b0, launch = 1'b0, m_sc = 1'b0;
  logic mem_we = 1'b0;
  logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00;
  i2cbm_buf_s bcfg = '0;
  i2cbm_mcmd_s mcmd = '0;
  logic scl_oe, sda_oe, p_scl, p_sda, irq;
  i2cbm_sstat_s sst;
  i2cbm_mstat_s mst;
  logic [7:0] rd_cnt, wr_cnt, m_cnt, mem_rdata;
  logic [8:0] rx;
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  // open drain, pulled up
  wire logic scl = !(scl_oe | p_scl);
  wire logic sda = !(sda_oe | p_sda);

  i2cbm_engine i2cbm_engine_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .own_addr(own), .sl_rd_setup(rd_su),
    .sl_wr_setup(wr_su), .sl_buf_cfg(bcfg), .sl_rd_clear(rd_cl),
    .sl_wr_clear(wr_cl), .sl_rd_stat_clear(rd_sc),
    .sl_wr_stat_clear(wr_sc), .sl_status(sst), .sl_rd_count(rd_cnt),
    .sl_wr_count(wr_cnt), .m_launch(launch), .m_cmd_in(mcmd),
    .m_stat_clear(m_sc), .m_status(mst), .m_count(m_cnt),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .irq(irq));
  i2cbm_bus_partner #(.SLV_ADDR(FAR)) i2cbm_bus_partner_inst (
    .scl(scl), .sda(sda), .scl_low(p_scl), .sda_low(p_sda));

  initial begin
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // shared tasks
  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic memw(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {mem_we, mem_addr, mem_wdata} = {1'b1, a, d};
    @(negedge clk);
    mem_we = 1'b0;
  endtask : memw
  task automatic memchk(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    mem_addr = a;
    @(negedge clk);
    `CMP("mem_rdata", d, mem_rdata);
  endtask : memchk
  // odd offset keeps the link clock out of step with clk
  task automatic p_start();
    @(negedge clk);
    #7;
    i2cbm_bus_partner_inst.m_start();
  endtask : p_start
  task automatic p_byte(input logic [8:0] x);
    i2cbm_bus_partner_inst.m_byte(x, rx);
  endtask : p_byte
  task automatic p_stop();
    i2cbm_bus_partner_inst.m_stop();
    repeat (5) @(negedge clk);
  endtask : p_stop
  // done then a full stop period before anything is judged
  task automatic mrun(input logic [6:0] a, input logic [7:0] base,
                      input logic [7:0] len, input logic [1:0] md);
    mcmd = {a, 1'b0, base, len, md};
    pulse(launch);
    for (int i = 0; i < 20000 && mst.wr_done !== 1'b1; i++) @(negedge clk);
    repeat (600) @(negedge clk);
  endtask : mrun

  // ==========================================================
  // scenarios
  task automatic t_reset();
    `CMP("sl_status", 6'h00, sst);
    `CMP("m_status", 8'h00, mst);
    `CMP("irq", 1'b0, irq);
  endtask : t_reset
  task automatic t_addr();
    p_start();
    p_byte({8'hFC, 1'b1});
    `CMP("other addr nak", 1'b1, rx[0]);
    p_stop();
    p_start();
    p_byte({8'hFE, 1'b1});
    `CMP("own addr ack", 1'b0, rx[0]);
    p_byte({8'h12, 1'b1});
    `CMP("unconfigured nak", 1'b1, rx[0]);
    p_stop();
    `CMP("no overrun", 1'b0, sst.wr_overrun);
    p_start();
    p_byte({8'hFF, 1'b1});
    p_byte({8'hFF, 1'b1});
    `CMP("unconfigured read", 8'hFF, rx[8:1]);
    p_stop();
    pulse(rd_sc);
    pulse(wr_sc);
  endtask : t_addr
  task automatic t_sread();
    memw(8'h20, 8'hC3);
    bcfg = {8'h20, 8'h01};
    pulse(rd_su);
    p_start();
    p_byte({8'hFF, 1'b1});
    `CMP("rd_active", 1'b1, sst.rd_active);
    p_byte({8'hFF, 1'b0});
    `CMP("read byte", 8'hC3, rx[8:1]);
    p_byte({8'hFF, 1'b1});
    `CMP("past end", 8'hFF, rx[8:1]);
    p_stop();
    `CMP("rd_done", 1'b1, sst.rd_done);
    `CMP("rd_active off", 1'b0, sst.rd_active);
    `CMP("rd_overrun", 1'b1, sst.rd_overrun);
    `CMP("rd_count", 8'h01, rd_cnt);
    pulse(rd_cl);
    `CMP("rd_count clear", 8'h00, rd_cnt);
    p_start();
    p_byte({8'hFF, 1'b1});
    p_byte({8'hFF, 1'b1});
    `CMP("restart byte", 8'hC3, rx[8:1]);
    p_stop();
  endtask : t_sread
  task automatic t_swrite();
    bcfg = {8'h10, 8'h02};
    pulse(wr_su);
    p_start();
    p_byte({8'hFE, 1'b1});
    `CMP("wr_active", 1'b1, sst.wr_active);
    p_byte({8'hA5, 1'b1});
    p_byte({8'h3C, 1'b1});
    `CMP("last fit ack", 1'b0, rx[0]);
    p_byte({8'h99, 1'b1});
    `CMP("overflow nak", 1'b1, rx[0]);
    `CMP("wr_overrun", 1'b1, sst.wr_overrun);
    p_stop();
    `CMP("wr_done", 1'b1, sst.wr_done);
    `CMP("wr_active off", 1'b0, sst.wr_active);
    `CMP("wr_count", 8'h02, wr_cnt);
    `CMP("irq set", 1'b1, irq);
    memchk(8'h10, 8'hA5);
    memchk(8'h11, 8'h3C);
    pulse(wr_cl);
    p_start();
    p_byte({8'hFE, 1'b1});
    p_byte({8'h5E, 1'b1});
    p_stop();
    memchk(8'h10, 8'h5E);
    `CMP("wr_count clear", 8'h01, wr_cnt);
  endtask : t_swrite
  task automatic t_sclear();
    `CMP("returned rd", 1'b1, sst.rd_done);
    pulse(rd_sc);
    `CMP("rd flags", 2'b00, {sst.rd_done, sst.rd_overrun});
    `CMP("wr kept", 2'b11, {sst.wr_done, sst.wr_overrun});
    pulse(wr_sc);
    `CMP("wr flags", 2'b00, {sst.wr_done, sst.wr_overrun});
    `CMP("irq clear", 1'b0, irq);
  endtask : t_sclear
  task automatic t_mwrite();
    memw(8'h40, 8'h81);
    memw(8'h41, 8'h7E);
    mrun(FAR, 8'h40, 8'h02, I2CBM_FULL_TRANSFER_OPTION);
    `CMP("bytes", 2, i2cbm_bus_partner_inst.got.size());
    `CMP("byte 0", 8'h81, i2cbm_bus_partner_inst.got[0]);
    `CMP("byte 1", 8'h7E, i2cbm_bus_partner_inst.got[1]);
    `CMP("m_count", 8'h02, m_cnt);
    `CMP("no error", 1'b0, mst.any_err);
    `CMP("returned m", 1'b1, mst.wr_done);
    pulse(m_sc);
    `CMP("m cleared", 8'h00, mst);
  endtask : t_mwrite
  task automatic t_merr();
    i2cbm_bus_partner_inst.nak_at = 1;
    mrun(FAR, 8'h40, 8'h02, 2'h0);
    `CMP("short_err", 1'b1, mst.short_err);
    `CMP("done anyway", 1'b1, mst.wr_done);
    `CMP("any_err", 1'b1, mst.any_err);
    `CMP("addr_err off", 1'b0, mst.addr_err);
    pulse(m_sc);
    i2cbm_bus_partner_inst.nak_at = 0;
    mrun(FAR, 8'h40, 8'h01, 2'h0);
    `CMP("addr_err", 1'b1, mst.addr_err);
    `CMP("any_err addr", 1'b1, mst.any_err);
    `CMP("irq master", 1'b1, irq);
    pulse(m_sc);
    i2cbm_bus_partner_inst.nak_at = 255;
  endtask : t_merr
  task automatic t_mhalt();
    i2cbm_bus_partner_inst.got.delete();
    mrun(FAR, 8'h40, 8'h01, 2'h2);
    `CMP("paused", 1'b1, mst.paused);
    `CMP("scl held", 1'b1, scl_oe);
    pulse(m_sc);
    mrun(FAR, 8'h41, 8'h01, 2'h1);
    `CMP("resumed", 1'b0, mst.paused);
    `CMP("scl free", 1'b0, scl_oe);
    `CMP("restart byte", 8'h7E, i2cbm_bus_partner_inst.got[1]);
  endtask : t_mhalt

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_addr();
    t_sread();
    t_swrite();
    t_sclear();
    t_mwrite();
    t_merr();
    t_mhalt();
    wrap_up();
  end
endmodule : test_i2c_buffered_master_slave
